// >>> stcp_timer.sv
// standard timer top: wishbone registers, counter, comparators, output pin
`timescale 1ns/1ps
`default_nettype none
module stcp_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic timebase_tick_i,
    input wire logic external_clock_pin_i,
    output logic timer_pin_a_o,
    output logic timer_pin_a_oe_o,
    output logic compare_a_flag_o,
    output logic compare_p_flag_o
);
    // ------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [15:0] compare_a_value;
    logic [7:0] compare_p_value;
    logic [15:0] count;
    logic compare_a_flag;
    logic compare_p_flag;
    logic ack;
    logic [7:0] rd_byte;

    wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack;
    wire logic bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire logic [7:0] wr_byte = wb_dat_i[7:0];
    wire logic wr_ctrl0 = bus_wr & (wb_adr_i == stcp_pkg::ADR_CTRL0);
    wire logic wr_ctrl1 = bus_wr & (wb_adr_i == stcp_pkg::ADR_CTRL1);
    wire logic wr_cmpa_lo = bus_wr & (wb_adr_i == stcp_pkg::ADR_CMPA_LO);
    wire logic wr_cmpa_hi = bus_wr & (wb_adr_i == stcp_pkg::ADR_CMPA_HI);
    wire logic wr_period = bus_wr & (wb_adr_i == stcp_pkg::ADR_PERIOD);
    wire logic wr_flags = bus_wr & (wb_adr_i == stcp_pkg::ADR_FLAGS);

    wire logic enable = ctrl0[stcp_pkg::C0_ENABLE];
    wire logic pause = ctrl0[stcp_pkg::C0_PAUSE];
    wire logic [2:0] clock_select = ctrl0[stcp_pkg::C0_CKSEL_LSB +: 3];
    wire logic [1:0] mode = ctrl1[stcp_pkg::C1_MODE_LSB +: 2];
    wire logic [1:0] out_fn = ctrl1[stcp_pkg::C1_FUNC_LSB +: 2];
    wire logic initial_state = ctrl1[stcp_pkg::C1_INIT];
    wire logic output_invert = ctrl1[stcp_pkg::C1_INV];
    wire logic period_duty_swap = ctrl1[stcp_pkg::C1_SWAP];
    wire logic clear_select = ctrl1[stcp_pkg::C1_CLRSEL];

    // reserved bits 2..0 of control 0 read as zero
    always_comb begin
        case (wb_adr_i)
            stcp_pkg::ADR_CTRL0: rd_byte = {ctrl0[7:3], 3'h0};
            stcp_pkg::ADR_CTRL1: rd_byte = ctrl1;
            stcp_pkg::ADR_CNT_LO: rd_byte = count[7:0];
            stcp_pkg::ADR_CNT_HI: rd_byte = count[15:8];
            stcp_pkg::ADR_CMPA_LO: rd_byte = compare_a_value[7:0];
            stcp_pkg::ADR_CMPA_HI: rd_byte = compare_a_value[15:8];
            stcp_pkg::ADR_PERIOD: rd_byte = compare_p_value;
            stcp_pkg::ADR_FLAGS: rd_byte = {6'h00, compare_p_flag, compare_a_flag};
            default: rd_byte = 8'h00;
        endcase
    end

    // every address is mapped, so each request is acked after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack <= bus_req;
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end
    assign wb_ack_o = ack;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0 <= stcp_pkg::RST_BYTE;
            ctrl1 <= stcp_pkg::RST_BYTE;
            compare_a_value <= 16'h0000;
            compare_p_value <= stcp_pkg::RST_BYTE;
        end else begin
            if (wr_ctrl0)
                ctrl0 <= wr_byte;
            if (wr_ctrl1)
                ctrl1 <= wr_byte;
            if (wr_cmpa_lo)
                compare_a_value[7:0] <= wr_byte;
            if (wr_cmpa_hi)
                compare_a_value[15:8] <= wr_byte;
            if (wr_period)
                compare_p_value <= wr_byte;
        end
    end

    // ------------------------------------------------------------
    // module clock selection
    // ------------------------------------------------------------
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic [5:0] div_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
            div_cnt <= 6'h00;
        end else begin
            ext_sync1 <= external_clock_pin_i;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
            div_cnt <= div_cnt + 6'h01;
        end
    end
    // high clock is taken as the system clock here; one free divider serves all taps
    wire logic tick4 = (div_cnt[1:0] == stcp_pkg::DIV4_LAST[1:0]);
    wire logic tick16 = (div_cnt[3:0] == stcp_pkg::DIV16_LAST[3:0]);
    wire logic tick64 = (div_cnt == stcp_pkg::DIV64_LAST);
    logic module_tick;
    always_comb begin
        case (clock_select)
            stcp_pkg::CK_SYS4: module_tick = tick4;
            stcp_pkg::CK_SYS: module_tick = 1'b1;
            stcp_pkg::CK_H16: module_tick = tick16;
            stcp_pkg::CK_H64: module_tick = tick64;
            stcp_pkg::CK_TBC: module_tick = timebase_tick_i;
            stcp_pkg::CK_PIN_RISE: module_tick = ext_sync2 & ~ext_prev;
            stcp_pkg::CK_PIN_FALL: module_tick = ~ext_sync2 & ext_prev;
            default: module_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // counter and comparators
    // ------------------------------------------------------------
    logic enable_d;
    wire logic enable_rise = enable & ~enable_d;
    wire logic step = enable & ~pause & module_tick & ~enable_rise;
    wire logic [15:0] count_inc = count + 16'h0001;
    wire logic is_pwm = (mode == stcp_pkg::MODE_PWM);
    // compare-P matches the top byte and needs a zero low byte; zero means wrap of the full counter
    wire logic match_p = step & ((compare_p_value == 8'h00) ? (count_inc == 16'h0000)
                                  : (count_inc[15:8] == compare_p_value && count_inc[7:0] == 8'h00));
    wire logic match_a = step & (count_inc == compare_a_value);
    wire logic clear_on_a = is_pwm ? period_duty_swap : clear_select;
    wire logic period_end = clear_on_a ? match_a : match_p;
    wire logic set_a = match_a;
    wire logic set_p = match_p & (is_pwm | ~clear_select);
    wire logic clr_a = wr_flags & wr_byte[stcp_pkg::FL_A];
    wire logic clr_p = wr_flags & wr_byte[stcp_pkg::FL_P];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_d <= 1'b0;
            count <= 16'h0000;
            compare_a_flag <= 1'b0;
            compare_p_flag <= 1'b0;
        end else begin
            enable_d <= enable;
            if (enable_rise)
                count <= 16'h0000;
            else if (step)
                count <= period_end ? 16'h0000 : count_inc;
            // a set in the same cycle as a clear wins
            compare_a_flag <= set_a | (compare_a_flag & ~clr_a);
            compare_p_flag <= set_p | (compare_p_flag & ~clr_p);
        end
    end
    assign compare_a_flag_o = compare_a_flag;
    assign compare_p_flag_o = compare_p_flag;

    // ------------------------------------------------------------
    // output pin
    // ------------------------------------------------------------
    // duty reaches when the counter, current value, passes the duty point
    wire logic [16:0] duty_len = period_duty_swap
        ? ((compare_p_value == 8'h00) ? 17'h10000 : {1'b0, compare_p_value, 8'h00})
        : {1'b0, compare_a_value};
    wire logic [16:0] period_len = period_duty_swap
        ? {1'b0, compare_a_value}
        : ((compare_p_value == 8'h00) ? 17'h10000 : {1'b0, compare_p_value, 8'h00});
    wire logic pwm_active = (duty_len >= period_len) | ({1'b0, count} < duty_len);
    logic pwm_level;
    always_comb begin
        case (out_fn)
            stcp_pkg::FN_NONE: pwm_level = ~initial_state;
            stcp_pkg::FN_LOW: pwm_level = initial_state;
            stcp_pkg::FN_HIGH: pwm_level = pwm_active ? initial_state : ~initial_state;
            default: pwm_level = ~initial_state;
        endcase
    end

    logic cmp_pin;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            cmp_pin <= 1'b0;
        else if (enable_rise)
            cmp_pin <= initial_state;
        else if (set_a && mode == stcp_pkg::MODE_CMP) begin
            case (out_fn)
                stcp_pkg::FN_LOW: cmp_pin <= 1'b0;
                stcp_pkg::FN_HIGH: cmp_pin <= 1'b1;
                stcp_pkg::FN_TOGGLE: cmp_pin <= ~cmp_pin;
                default: cmp_pin <= cmp_pin;
            endcase
        end
    end

    logic pin;
    logic pin_oe;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin <= (is_pwm ? pwm_level : cmp_pin) ^ output_invert;
            pin_oe <= (mode == stcp_pkg::MODE_CMP) | is_pwm;
        end
    end
    assign timer_pin_a_o = pin;
    assign timer_pin_a_oe_o = pin_oe;

    // ------------------------------------------------------------
    // checks: counter and compare-A register writes
    // ------------------------------------------------------------
    chk_enable_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_rise |=> (count == 16'h0000))
        else $error("enable rise did not clear counter");

    chk_hold_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
        (!enable && !enable_d) |=> $stable(count))
        else $error("counter moved while off");

    chk_count_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (!step && !enable_rise) |=> $stable(count))
        else $error("counter moved without a step");

    chk_step_inc: assert property (@(posedge clk_i) disable iff (rst_i)
        (step && !period_end) |=> (count == $past(count) + 16'h0001))
        else $error("counter did not advance by one");

    chk_period_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (step && period_end) |=> (count == 16'h0000))
        else $error("period end did not clear counter");

    chk_p_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (step && !clear_on_a && compare_p_value == 8'h00) |-> (period_end == (count == 16'hffff)))
        else $error("zero compare-P did not wrap at full count");

    chk_p_match_top: assert property (@(posedge clk_i) disable iff (rst_i)
        (match_p && compare_p_value != 8'h00) |-> (count_inc[7:0] == 8'h00))
        else $error("P match off boundary");

    chk_p_match_byte: assert property (@(posedge clk_i) disable iff (rst_i)
        (match_p && compare_p_value != 8'h00) |-> (count_inc[15:8] == compare_p_value))
        else $error("P match on wrong top byte");

    chk_rsvd_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        (clock_select == stcp_pkg::CK_RSVD) |-> !step)
        else $error("reserved clock select counted");

    chk_sys_steps: assert property (@(posedge clk_i) disable iff (rst_i)
        (clock_select == stcp_pkg::CK_SYS && enable && !pause && !enable_rise) |-> step)
        else $error("system clock select missed a step");

    chk_pause_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (pause && !enable_rise) |=> $stable(count))
        else $error("counter moved while paused");

    chk_a_write_lo: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cmpa_lo |=> (compare_a_value[7:0] == $past(wr_byte)))
        else $error("compare-A low byte not written");

    chk_a_write_hi: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cmpa_hi |=> (compare_a_value[15:8] == $past(wr_byte)))
        else $error("compare-A high byte not written");

    // ------------------------------------------------------------
    // checks: flags and pin
    // ------------------------------------------------------------
    chk_no_p_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (!is_pwm && clear_select && !compare_p_flag && !wr_ctrl1) |=> !compare_p_flag)
        else $error("compare-P flag set with clear on A");

    chk_p_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (match_p && (is_pwm || !clear_select)) |=> compare_p_flag)
        else $error("P flag missed");

    chk_flag_a_set: assert property (@(posedge clk_i) disable iff (rst_i)
        match_a |=> compare_a_flag)
        else $error("A flag missed");

    chk_a_flag_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (!match_a && !compare_a_flag) |=> !compare_a_flag)
        else $error("A flag set without a match");

    chk_init_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_rise |=> (cmp_pin == $past(initial_state)))
        else $error("pin not at initial level");

    chk_pin_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!set_a && !enable_rise) |=> $stable(cmp_pin))
        else $error("pin changed without A match");

    chk_cmp_high: assert property (@(posedge clk_i) disable iff (rst_i)
        (set_a && !enable_rise && mode == stcp_pkg::MODE_CMP && out_fn == stcp_pkg::FN_HIGH) |=> cmp_pin)
        else $error("pin not set high on A match");

    chk_cmp_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (set_a && !enable_rise && mode == stcp_pkg::MODE_CMP && out_fn == stcp_pkg::FN_LOW) |=> !cmp_pin)
        else $error("pin not set low on A match");

    chk_cmp_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        (set_a && !enable_rise && mode == stcp_pkg::MODE_CMP && out_fn == stcp_pkg::FN_TOGGLE)
        |=> (cmp_pin != $past(cmp_pin)))
        else $error("pin did not toggle on A match");

    chk_cmp_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == stcp_pkg::MODE_CMP)
        |=> (timer_pin_a_oe_o && timer_pin_a_o == ($past(cmp_pin) ^ $past(output_invert))))
        else $error("compare pin not driven from compare level");

    chk_timer_nodrive: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == stcp_pkg::MODE_TMR) |=> !timer_pin_a_oe_o)
        else $error("pin driven in timer mode");

    chk_pwm_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        is_pwm |=> timer_pin_a_oe_o)
        else $error("pin not driven in pwm mode");

    chk_pwm_inactive: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_pwm && out_fn == stcp_pkg::FN_NONE)
        |=> (timer_pin_a_o == (~$past(initial_state) ^ $past(output_invert))))
        else $error("forced inactive level wrong");

    chk_pwm_active: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_pwm && out_fn == stcp_pkg::FN_LOW)
        |=> (timer_pin_a_o == ($past(initial_state) ^ $past(output_invert))))
        else $error("forced active level wrong");

    chk_full_duty: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_pwm && out_fn == stcp_pkg::FN_HIGH && duty_len >= period_len)
        |=> (timer_pin_a_o == ($past(initial_state) ^ $past(output_invert))))
        else $error("full duty not active");
endmodule : stcp_timer
`default_nettype wire

// >>> stcp_pkg.sv
// package for the standard timer with compare and pwm: register map, fields, codes
package stcp_pkg;
    localparam logic [2:0] ADR_CTRL0 = 3'h0;
    localparam logic [2:0] ADR_CTRL1 = 3'h1;
    localparam logic [2:0] ADR_CNT_LO = 3'h2;
    localparam logic [2:0] ADR_CNT_HI = 3'h3;
    localparam logic [2:0] ADR_CMPA_LO = 3'h4;
    localparam logic [2:0] ADR_CMPA_HI = 3'h5;
    localparam logic [2:0] ADR_PERIOD = 3'h6;
    localparam logic [2:0] ADR_FLAGS = 3'h7;
    // control 0 fields
    localparam int C0_PAUSE = 7;
    localparam int C0_CKSEL_LSB = 4;
    localparam int C0_ENABLE = 3;
    // control 1 fields
    localparam int C1_MODE_LSB = 6;
    localparam int C1_FUNC_LSB = 4;
    localparam int C1_INIT = 3;
    localparam int C1_INV = 2;
    localparam int C1_SWAP = 1;
    localparam int C1_CLRSEL = 0;
    // flag register fields, write one to clear
    localparam int FL_A = 0;
    localparam int FL_P = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    localparam logic [1:0] FN_NONE = 2'h0;
    localparam logic [1:0] FN_LOW = 2'h1;
    localparam logic [1:0] FN_HIGH = 2'h2;
    localparam logic [1:0] FN_TOGGLE = 2'h3;
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_TBC = 3'h4;
    localparam logic [2:0] CK_RSVD = 3'h5;
    localparam logic [2:0] CK_PIN_RISE = 3'h6;
    localparam logic [2:0] CK_PIN_FALL = 3'h7;
    localparam logic [5:0] DIV4_LAST = 6'h03;
    localparam logic [5:0] DIV16_LAST = 6'h0f;
    localparam logic [5:0] DIV64_LAST = 6'h3f;
endpackage : stcp_pkg

// >>> stcp_pin_load.sv
// pin load model: pulled-down wire with a run-length meter on its level
`timescale 1ns/1ps
`default_nettype none
module stcp_pin_load (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic oe_i,
    output logic level_o,
    output logic [31:0] high_width_o,
    output logic [31:0] low_width_o
);
    logic prev;
    logic [31:0] run;
    // the pull-down wins whenever the timer lets go of the wire
    assign level_o = oe_i ? pin_i : 1'b0;
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev <= 1'b0;
            run <= 32'h0;
            high_width_o <= 32'h0;
            low_width_o <= 32'h0;
        end else if (level_o != prev) begin
            prev <= level_o;
            run <= 32'h1;
            if (prev) high_width_o <= run;
            else low_width_o <= run;
        end else begin
            run <= run + 32'h1;
        end
    end
endmodule : stcp_pin_load
`default_nettype wire

// >>> standard_timer_compare_pwm_tb.sv
// self-checking bench for the timer: registers, compare output and pwm
`timescale 1ns/1ps
`default_nettype none
module standard_timer_compare_pwm_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] adr = 3'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic ack, pin, oe, fa, fp, level;
    logic [31:0] hw, lw;
    logic [2:0] div = 3'h0;
    logic [7:0] h, l, q;
    int mismatches = 0;
    int num_checks = 0;
    // {address, write, data, expected read}
    logic [19:0] rows [0:12] = '{20'h00000, 20'h20000, 20'h40000, 20'h60000, 20'h80000, 20'ha0000,
        20'hc0000, 20'he0000, 20'h95a5a, 20'hba5a5, 20'hd3c3c, 20'h5ff00, 20'h7ff00};
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) div <= div + 3'h1;
    stcp_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
        .timebase_tick_i(div == 3'h0), .external_clock_pin_i(div[2]), .timer_pin_a_o(pin),
        .timer_pin_a_oe_o(oe), .compare_a_flag_o(fa), .compare_p_flag_o(fp));
    stcp_pin_load load (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin), .oe_i(oe), .level_o(level),
        .high_width_o(hw), .low_width_o(lw));
    // ----------------------------------------
    // bus cycles and comparison
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; ack is sampled on a rising edge, where data is taken and the request dropped
    task automatic wb(input logic [2:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        adr <= a;
        we <= w;
        wdat <= {24'h0, d};
        cyc <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            summarize();
        end
        r = rdat[7:0];
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(a, 1'b1, d, r);
    endtask : wr
    task automatic run(input logic [7:0] c1, input int cycles);
        wr(3'h0, 8'h00);
        wr(3'h1, c1);
        wr(3'h7, 8'h03);
        wr(3'h0, 8'h18);
        repeat (cycles) @(posedge clk_i);
    endtask : run
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 13; i++) begin
            wb(rows[i][19:17], rows[i][16], rows[i][15:8], q);
            if (rows[i][16]) wb(rows[i][19:17], 1'b0, 8'h00, q);
            chk({24'h0, q}, {24'h0, rows[i][7:0]});
        end
        for (int cs = 0; cs < 8; cs++) begin
            wr(3'h0, 8'h00);
            wr(3'h0, {1'b0, 3'(cs), 4'h8});
            repeat (200) @(posedge clk_i);
            wr(3'h0, 8'h00);
            wb(3'h3, 1'b0, 8'h00, h);
            wb(3'h2, 1'b0, 8'h00, l);
            chk({31'h0, |{h, l}}, {31'h0, cs != 5});
            wb(3'h2, 1'b0, 8'h00, q);
            chk({24'h0, q}, {24'h0, l});
        end
        wr(3'h4, 8'h10);
        wr(3'h5, 8'h00);
        wr(3'h6, 8'h01);
        run(8'h30, 800);
        chk(hw, 32'd256);
        chk(lw, 32'd256);
        chk({oe, fa, fp}, 32'h7);
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h02);
        run(8'h31, 1600);
        chk(hw, 32'd512);
        chk({fa, fp}, 32'h2);
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h10);
        wr(3'h5, 8'h00);
        run(8'h08, 1);
        wb(3'h3, 1'b0, 8'h00, q);
        chk({24'h0, q}, 32'h0);
        repeat (600) @(posedge clk_i);
        chk({level, fa}, 32'h3);
        run(8'hc0, 600);
        chk({oe, level, fa, fp}, 32'h3);
        wr(3'h4, 8'h40);
        run(8'ha8, 800);
        chk(hw, 32'd64);
        chk({lw[15:0], 14'h0, fa, fp}, {16'd192, 16'h3});
        run(8'had, 800);
        chk({hw[15:0], lw[15:0]}, {16'd192, 16'd64});
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h03);
        run(8'haa, 2400);
        chk({hw[15:0], lw[15:0]}, {16'd256, 16'd512});
        run(8'ha8, 600);
        chk({31'h0, level}, 32'h1);
        for (int f = 0; f < 2; f++) begin
            run({3'h4, 1'(f), 4'h8}, 300);
            chk({31'h0, level}, 32'(f));
        end
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({30'h0, fa, fp}, 32'h0);
        wb(3'h5, 1'b0, 8'h00, q);
        chk({24'h0, q}, 32'h0);
        wb(3'h2, 1'b0, 8'h00, q);
        chk({24'h0, q}, 32'h0);
        summarize();
    end
endmodule : standard_timer_compare_pwm_tb
`default_nettype wire
